// [hw/sic_defines.svh]
// Constants of the scanner input conditioning block
`ifndef SIC_DEFINES_SVH
`define SIC_DEFINES_SVH

`define SIC_CLK_FREQ_HZ      125000000
`define SIC_DEB_LONG_US      5000
`define SIC_DEB_SHORT_US     500
`define SIC_DEB_LONG_CYC     ((`SIC_CLK_FREQ_HZ / 1000000) * `SIC_DEB_LONG_US)
`define SIC_DEB_SHORT_CYC    ((`SIC_CLK_FREQ_HZ / 1000000) * `SIC_DEB_SHORT_US)
`define SIC_CNT_W            20
`define SIC_ENC_MAX_HZ       2000
`define SIC_SPEED_WIN_MS     100
`define SIC_SPEED_WIN_CYC    ((`SIC_CLK_FREQ_HZ / 1000) * `SIC_SPEED_WIN_MS)
`define SIC_SPEED_W          16

`define SIC_ADDR_CTRL        4'h0
`define SIC_ADDR_STATUS      4'h1
`define SIC_ADDR_IRQ_STAT    4'h2
`define SIC_ADDR_IRQ_MASK    4'h3
`define SIC_ADDR_SPEED       4'h4
`define SIC_ADDR_ENC_COUNT   4'h5

`define SIC_CTRL_POL_LSB     0
`define SIC_CTRL_DEB_TRG     4
`define SIC_CTRL_DEB_ENC     5
`define SIC_CTRL_STOP3_EN    6
`define SIC_CTRL_STOP4_EN    7
`define SIC_CTRL_ONLINE      8
`define SIC_CTRL_RESET       32'h0000_0110

`define SIC_IRQ_TRIG_ON      0
`define SIC_IRQ_TRIG_OFF     1
`define SIC_IRQ_ENC_PULSE    2
`define SIC_IRQ_STOP         3
`define SIC_IRQ_W            4

`endif

// [hw/sic_pkg.sv]
// Types of the scanner input conditioning block
package sic_pkg;
  typedef enum logic [1:0] {
    SIC_IDLE,
    SIC_SCAN
  } sic_phase_e;
  typedef logic [31:0] sic_word_t;
endpackage : sic_pkg

// [hw/sic_filt_if.sv]
// Carrier between the main block and one debounce filter
interface sic_filt_if;
  logic raw;
  logic long_sel;
  logic level;
  logic rise;
  logic fall;
  modport filt (input raw, input long_sel, output level, output rise, output fall);
  modport user (output raw, output long_sel, input level, input rise, input fall);
endinterface : sic_filt_if

// [hw/sic_debounce.sv]
// Debounce filter for one input with a selectable delay
`include "sic_defines.svh"
module sic_debounce (
  input  wire logic  clock,
  input  wire logic  reset,
  sic_filt_if.filt   fi
);
  logic [`SIC_CNT_W-1:0] cnt_q, cnt_d, lim;
  logic                  lvl_q, lvl_d;
  logic                  rise_q, rise_d, fall_q, fall_d;

  always_comb
  begin
    lim    = fi.long_sel ? `SIC_CNT_W'(`SIC_DEB_LONG_CYC - 1) : `SIC_CNT_W'(`SIC_DEB_SHORT_CYC - 1);
    cnt_d  = '0;
    lvl_d  = lvl_q;
    rise_d = 1'b0;
    fall_d = 1'b0;
    if (fi.raw != lvl_q)
    begin
      // New level accepted only after a full stable delay
      if (cnt_q >= lim)
      begin
        lvl_d  = fi.raw;
        rise_d = fi.raw;
        fall_d = !fi.raw;
      end
      else
        cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clock)
    if (reset)
    begin
      cnt_q  <= '0;
      lvl_q  <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      lvl_q  <= lvl_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end

  assign fi.level = lvl_q;
  assign fi.rise  = rise_q;
  assign fi.fall  = fall_q;

  chk_stable_before_change: assert property (@(posedge clock) disable iff (reset)
    (lvl_q != $past(lvl_q)) |-> ($past(fi.raw) == lvl_q && $past(cnt_q) >= $past(lim)))
    else $error("debounce level changed before full delay");
endmodule : sic_debounce

// [hw/sic_scanner_inputs.sv]
// Scanner input conditioning top: four filtered inputs, Avalon-MM registers
//
// Function
// - Every input is debounced with a selectable 5 ms or 500 us delay.
// - Trigger and both generic inputs share one delay; encoder has its own.
// - Each input's active state is chosen: active open or active closed.
// - Encoder pulses up to 2 kHz are to be handled, faster encoders not allowed; the 500 us delay passes levels only up to 1 kHz.
// - In on-line mode an active trigger commands a code scan.
// - Phase indicator shows raw current on trigger, ignoring polarity.
// - A generic input, when enabled, ends the reading phase on activation.
// - Debounced encoder pulses give conveyor speed to the reading logic.
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`include "sic_defines.svh"
module sic_scanner_inputs (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         trigger_input,
  input  wire logic         encoder_input,
  input  wire logic         generic_input_three,
  input  wire logic         generic_input_four,
  input  wire logic [3:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  output logic              scan_request,
  output logic              phase_stop,
  output logic              encoder_pulse,
  output logic [15:0]       conveyor_speed,
  output logic              phase_indicator,
  output logic              irq
);
  // Raw inputs are high while current flows through the optocoupler
  logic [3:0]  raw;
  logic [3:0]  logical;
  logic [3:0]  act_rise;
  logic [3:0]  act_fall;

  sic_pkg::sic_word_t ctrl_q, ctrl_d;
  logic [`SIC_IRQ_W-1:0] ists_q, ists_d, imask_q, imask_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ack_q, ack_d;
  logic [`SIC_SPEED_W-1:0] win_pulses_q, win_pulses_d, speed_q, speed_d;
  logic [23:0] win_cnt_q, win_cnt_d;
  logic [31:0] enc_count_q, enc_count_d;
  sic_pkg::sic_phase_e phase_q, phase_d;
  logic        scan_req_q, scan_req_d, stop_q, stop_d, encp_q, encp_d;
  logic [`SIC_IRQ_W-1:0] ev;
  logic [31:0] wmask;

  assign raw = {generic_input_four, generic_input_three, encoder_input, trigger_input};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_filt
      sic_filt_if fif ();
      logic pol;
      assign pol          = ctrl_q[`SIC_CTRL_POL_LSB + gi];
      assign fif.raw      = raw[gi];
      // Encoder uses its own delay bit, the others share one
      assign fif.long_sel = (gi == 1) ? ctrl_q[`SIC_CTRL_DEB_ENC]
                                      : ctrl_q[`SIC_CTRL_DEB_TRG];
      // pol = 1 means active open: logical state is inverted current
      assign logical[gi]  = fif.level ^ pol;
      assign act_rise[gi] = pol ? fif.fall : fif.rise;
      assign act_fall[gi] = pol ? fif.rise : fif.fall;
      sic_debounce u_deb (
        .clock (clock),
        .reset (reset),
        .fi    (fif.filt)
      );
    end
  endgenerate

  // Indicator follows the raw current flow, not the logical state
  assign phase_indicator = raw[0];

  // Reading phase control
  always_comb
  begin
    phase_d    = phase_q;
    scan_req_d = 1'b0;
    stop_d     = 1'b0;
    if (phase_q == sic_pkg::SIC_IDLE)
    begin
      if (ctrl_q[`SIC_CTRL_ONLINE] && act_rise[0])
      begin
        phase_d    = sic_pkg::SIC_SCAN;
        scan_req_d = 1'b1;
      end
    end
    else if ((ctrl_q[`SIC_CTRL_STOP3_EN] && act_rise[2]) ||
             (ctrl_q[`SIC_CTRL_STOP4_EN] && act_rise[3]))
    begin
      phase_d = sic_pkg::SIC_IDLE;
      stop_d  = 1'b1;
    end
    else if (act_fall[0] && !ctrl_q[`SIC_CTRL_STOP3_EN] && !ctrl_q[`SIC_CTRL_STOP4_EN])
      phase_d = sic_pkg::SIC_IDLE;
  end

  always_ff @(posedge clock)
    if (reset)
    begin
      phase_q    <= sic_pkg::SIC_IDLE;
      scan_req_q <= 1'b0;
      stop_q     <= 1'b0;
    end
    else
    begin
      phase_q    <= phase_d;
      scan_req_q <= scan_req_d;
      stop_q     <= stop_d;
    end

  assign scan_request = scan_req_q;
  assign phase_stop   = stop_q;

  // Conveyor speed: debounced encoder pulses per fixed window
  always_comb
  begin
    // One pulse per accepted encoder edge into the active state; with the 500 us delay only rates up to 1 kHz get through
    encp_d       = act_rise[1];
    enc_count_d  = enc_count_q + {31'h0, act_rise[1]};
    win_cnt_d    = win_cnt_q + 24'h1;
    win_pulses_d = win_pulses_q + {15'h0, act_rise[1]};
    speed_d      = speed_q;
    if (win_cnt_q == 24'(`SIC_SPEED_WIN_CYC - 1))
    begin
      win_cnt_d    = '0;
      speed_d      = win_pulses_d;
      win_pulses_d = '0;
    end
  end

  always_ff @(posedge clock)
    if (reset)
    begin
      encp_q       <= 1'b0;
      enc_count_q  <= '0;
      win_cnt_q    <= '0;
      win_pulses_q <= '0;
      speed_q      <= '0;
    end
    else
    begin
      encp_q       <= encp_d;
      enc_count_q  <= enc_count_d;
      win_cnt_q    <= win_cnt_d;
      win_pulses_q <= win_pulses_d;
      speed_q      <= speed_d;
    end

  assign encoder_pulse  = encp_q;
  assign conveyor_speed = speed_q;

  // Avalon-MM slave: one wait cycle, answer on the second edge
  assign ev = {stop_q, encp_q, act_fall[0], act_rise[0]};
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

  always_comb
  begin
    ack_d   = (avs_read || avs_write) && !ack_q;
    ctrl_d  = ctrl_q;
    imask_d = imask_q;
    rdata_d = rdata_q;
    // Set wins over a simultaneous write-one clear
    ists_d  = ists_q;
    if (avs_write && ack_q)
    begin
      unique case (avs_address)
        `SIC_ADDR_CTRL:     ctrl_d  = (ctrl_q & ~wmask) | (avs_writedata & wmask);
        `SIC_ADDR_IRQ_STAT: ists_d  = ists_q & ~(avs_writedata[`SIC_IRQ_W-1:0] & wmask[3:0]);
        `SIC_ADDR_IRQ_MASK: imask_d = avs_writedata[`SIC_IRQ_W-1:0];
        default:            ;
      endcase
    end
    ists_d = ists_d | ev;
    if (avs_read && !ack_q)
    begin
      unique case (avs_address)
        `SIC_ADDR_CTRL:      rdata_d = ctrl_q;
        `SIC_ADDR_STATUS:    rdata_d = {23'h0, phase_q == sic_pkg::SIC_SCAN,
                                        raw, logical};
        `SIC_ADDR_IRQ_STAT:  rdata_d = {28'h0, ists_q};
        `SIC_ADDR_IRQ_MASK:  rdata_d = {28'h0, imask_q};
        `SIC_ADDR_SPEED:     rdata_d = {16'h0, speed_q};
        `SIC_ADDR_ENC_COUNT: rdata_d = enc_count_q;
        default:             rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock)
    if (reset)
    begin
      ack_q   <= 1'b0;
      ctrl_q  <= `SIC_CTRL_RESET;
      ists_q  <= '0;
      imask_q <= '0;
      rdata_q <= '0;
    end
    else
    begin
      ack_q   <= ack_d;
      ctrl_q  <= ctrl_d;
      ists_q  <= ists_d;
      imask_q <= imask_d;
      rdata_q <= rdata_d;
    end

  assign avs_readdata = rdata_q;
  assign irq          = |(ists_q & imask_q);

  chk_scan_online: assert property (@(posedge clock) disable iff (reset)
    scan_request |-> ($past(ctrl_q[`SIC_CTRL_ONLINE]) && phase_q == sic_pkg::SIC_SCAN))
    else $error("scan request without on-line mode");
  chk_indicator_raw: assert property (@(posedge clock) disable iff (reset)
    phase_indicator == trigger_input)
    else $error("phase indicator not raw current");
  chk_stop_enable: assert property (@(posedge clock) disable iff (reset)
    phase_stop |-> ($past(ctrl_q[`SIC_CTRL_STOP3_EN]) || $past(ctrl_q[`SIC_CTRL_STOP4_EN])))
    else $error("stop without enabled generic input");
  chk_stop_idles: assert property (@(posedge clock) disable iff (reset)
    phase_stop |-> phase_q == sic_pkg::SIC_IDLE)
    else $error("stop did not end phase");
  chk_enc_count: assert property (@(posedge clock) disable iff (reset)
    encoder_pulse |-> enc_count_q == $past(enc_count_q) + 32'h1)
    else $error("encoder pulse not counted");
  chk_polarity: assert property (@(posedge clock) disable iff (reset)
    ($changed(ctrl_q[`SIC_CTRL_POL_LSB]) && $stable(g_filt[0].fif.level)) |->
      $changed(logical[0]))
    else $error("trigger polarity wrong");
  chk_shared_delay: assert property (@(posedge clock) disable iff (reset)
    g_filt[0].fif.long_sel == g_filt[2].fif.long_sel &&
    g_filt[2].fif.long_sel == g_filt[3].fif.long_sel)
    else $error("trigger and generic delays differ");
  // A raised interrupt drops only through a status clear or a mask write
  chk_irq_level: assert property (@(posedge clock) disable iff (reset)
    $fell(irq) |-> $past(avs_write && ack_q &&
                         (avs_address == `SIC_ADDR_IRQ_STAT || avs_address == `SIC_ADDR_IRQ_MASK)))
    else $error("irq dropped without a clear");

  // Steps of a reading phase and of encoder counting: an edge of the active state, then the registered pulse
  sequence s_trigger_on;
    $rose(logical[0]) && $stable(ctrl_q[`SIC_CTRL_POL_LSB]) &&
    ctrl_q[`SIC_CTRL_ONLINE] && phase_q == sic_pkg::SIC_IDLE;
  endsequence
  sequence s_scan_begins;
    scan_request && phase_q == sic_pkg::SIC_SCAN;
  endsequence
  sequence s_stop_on;
    phase_q == sic_pkg::SIC_SCAN && $stable(ctrl_q[`SIC_CTRL_POL_LSB +: 4]) &&
    ((ctrl_q[`SIC_CTRL_STOP3_EN] && $rose(logical[2])) ||
     (ctrl_q[`SIC_CTRL_STOP4_EN] && $rose(logical[3])));
  endsequence
  sequence s_phase_ends;
    phase_stop && phase_q == sic_pkg::SIC_IDLE;
  endsequence
  sequence s_encoder_on;
    $rose(logical[1]) && $stable(ctrl_q[`SIC_CTRL_POL_LSB + 1]);
  endsequence
  sequence s_encoder_counted;
    encoder_pulse && enc_count_q == $past(enc_count_q) + 32'h1;
  endsequence

  // Each step follows the previous one by one clock
  chk_scan_start: assert property (@(posedge clock) disable iff (reset)
    s_trigger_on |=> s_scan_begins)
    else $error("active trigger did not start a scan");
  chk_stop_ends: assert property (@(posedge clock) disable iff (reset)
    s_stop_on |=> s_phase_ends)
    else $error("enabled stop input did not end the phase");
  chk_enc_pulse: assert property (@(posedge clock) disable iff (reset)
    s_encoder_on |=> s_encoder_counted)
    else $error("encoder edge not counted");

  // Cycles for which the raw trigger has differed from its accepted level
  logic [`SIC_CNT_W-1:0] trg_held_q, trg_held_d;
  always_comb
  begin
    trg_held_d = '0;
    if (raw[0] != g_filt[0].fif.level)
      trg_held_d = trg_held_q + 1'b1;
  end
  always_ff @(posedge clock)
    if (reset)
      trg_held_q <= '0;
    else
      trg_held_q <= trg_held_d;

  chk_trigger_hold: assert property (@(posedge clock) disable iff (reset)
    $changed(g_filt[0].fif.level) |-> $past(trg_held_q) >=
      ($past(g_filt[0].fif.long_sel) ? `SIC_CNT_W'(`SIC_DEB_LONG_CYC - 1)
                                     : `SIC_CNT_W'(`SIC_DEB_SHORT_CYC - 1)))
    else $error("trigger accepted before its full delay");
endmodule : sic_scanner_inputs

// [tb/sic_field_sensors.sv]
// Far-side model: presence sensor, conveyor encoder and controller outputs
module sic_field_sensors (
  input  wire logic clock,
  output logic      trigger_input,
  output logic      encoder_input,
  output logic      generic_input_three,
  output logic      generic_input_four
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half period of the fastest legal encoder, in ns
  localparam time ENC_GAP = 250000;
  time last_edge = 0;
  initial
  begin
    trigger_input = 1'b0;
    encoder_input = 1'b0;
    generic_input_three = 1'b0;
    generic_input_four = 1'b0;
  end
  // Contact chatter, then settles closed
  task automatic trigger_bounce(input int high_cyc, input int low_cyc);
    @(posedge clock);
    trigger_input <= 1'b1;
    repeat (high_cyc) @(posedge clock);
    trigger_input <= 1'b0;
    repeat (low_cyc) @(posedge clock);
    trigger_input <= 1'b1;
  endtask : trigger_bounce
  task automatic encoder_step(input logic level);
    if (last_edge != 0)
      while ($time - last_edge < ENC_GAP) @(posedge clock);
    @(posedge clock);
    encoder_input <= level;
    last_edge = $time;
  endtask : encoder_step
  task automatic set_generic(input logic three, input logic four);
    @(posedge clock);
    generic_input_three <= three;
    generic_input_four <= four;
  endtask : set_generic
endmodule : sic_field_sensors

// [tb/sic_scanner_inputs_test.sv]
// Self-checking bench of the scanner input conditioning block
`include "sic_defines.svh"
module sic_scanner_inputs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = `SIC_DEB_SHORT_CYC;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] rd;
  wire  [31:0] avs_readdata;
  wire  [15:0] conveyor_speed;
  wire         avs_waitrequest, scan_request, phase_stop, encoder_pulse, phase_indicator, irq;
  wire         trigger_input, encoder_input, generic_input_three, generic_input_four;
  int          errors = 0, comparisons = 0, cyc = 0, n_scan = 0, n_stop = 0, n_enc = 0;
  int          t_scan = 0, t_stop = 0, t_enc = 0, t0, t1, t3;
  always #4 clock = ~clock;
  sic_field_sensors u_sic_field_sensors (.clock(clock), .trigger_input(trigger_input),
    .encoder_input(encoder_input), .generic_input_three(generic_input_three),
    .generic_input_four(generic_input_four));
  sic_scanner_inputs u_sic_scanner_inputs (.clock(clock), .reset(reset),
    .trigger_input(trigger_input), .encoder_input(encoder_input),
    .generic_input_three(generic_input_three), .generic_input_four(generic_input_four),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scan_request(scan_request), .phase_stop(phase_stop),
    .encoder_pulse(encoder_pulse), .conveyor_speed(conveyor_speed),
    .phase_indicator(phase_indicator), .irq(irq));
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  // One Avalon access; waitrequest low, read data and release meet at one rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    do
      @(posedge clock);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic complete_run;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  always @(negedge clock)
  begin
    cyc++;
    if (!reset)
      check(phase_indicator, trigger_input, "indicator");
    n_scan += (scan_request === 1'b1);
    if (scan_request === 1'b1) t_scan = cyc;
    n_stop += (phase_stop === 1'b1);
    if (phase_stop === 1'b1) t_stop = cyc;
    n_enc += (encoder_pulse === 1'b1);
    if (encoder_pulse === 1'b1) t_enc = cyc;
  end
  initial
  begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    bus(1'b0, `SIC_ADDR_CTRL, 32'h0);
    check(rd, `SIC_CTRL_RESET, "ctrl reset");
    bus(1'b0, 4'hF, 32'h0);
    check(rd, 32'h0, "unmapped read");
    bus(1'b1, `SIC_ADDR_CTRL, 32'h0000_010F);
    bus(1'b0, `SIC_ADDR_CTRL, 32'h0);
    check(rd, 32'h0000_010F, "ctrl written");
    bus(1'b0, `SIC_ADDR_STATUS, 32'h0);
    check(rd, 32'h0000_000F, "status all active open");
    // Short delays, input four active open, stop on input three, on-line
    bus(1'b1, `SIC_ADDR_CTRL, 32'h0000_0148);
    bus(1'b1, `SIC_ADDR_IRQ_MASK, 32'h0000_0001);
    bus(1'b0, `SIC_ADDR_STATUS, 32'h0);
    check(rd, 32'h0000_0008, "status idle");
    check(irq, 1'b0, "irq idle");
    u_sic_field_sensors.trigger_bounce(50, 20);
    t0 = cyc;
    u_sic_field_sensors.encoder_step(1'b1);
    t1 = cyc;
    repeat (1000) @(posedge clock);
    u_sic_field_sensors.set_generic(1'b1, 1'b0);
    t3 = cyc;
    for (int i = 0; i < DLY + 100 && n_scan == 0; i++) @(negedge clock);
    check(t_scan - t0 >= DLY && t_scan - t0 <= DLY + 6, 1'b1, "scan delay");
    bus(1'b0, `SIC_ADDR_STATUS, 32'h0);
    check(rd, 32'h0000_017B, "status scan");
    check(irq, 1'b1, "irq on");
    for (int i = 0; i < DLY + 100 && n_stop == 0; i++) @(negedge clock);
    check(t_stop - t3 >= DLY && t_stop - t3 <= DLY + 6, 1'b1, "stop delay");
    check(t_enc - t1 >= DLY && t_enc - t1 <= DLY + 6, 1'b1, "enc delay");
    check(n_scan, 1, "scan pulses");
    check(n_stop, 1, "stop pulses");
    check(n_enc, 1, "enc pulses");
    bus(1'b0, `SIC_ADDR_STATUS, 32'h0);
    check(rd, 32'h0000_007F, "status stopped");
    bus(1'b0, `SIC_ADDR_IRQ_STAT, 32'h0);
    check(rd, 32'h0000_000D, "irq status");
    bus(1'b1, `SIC_ADDR_IRQ_STAT, 32'h0000_000F);
    bus(1'b0, `SIC_ADDR_IRQ_STAT, 32'h0);
    check(rd, 32'h0, "irq cleared");
    check(irq, 1'b0, "irq off");
    bus(1'b0, `SIC_ADDR_ENC_COUNT, 32'h0);
    check(rd, 32'h0000_0001, "encoder count");
    bus(1'b0, `SIC_ADDR_SPEED, 32'h0);
    check(rd, 32'h0, "speed before first window");
    check(conveyor_speed, 16'h0000, "speed output");
    complete_run();
  end
  initial
  begin
    repeat (DLY + 20000) @(posedge clock);
    errors++;
    complete_run();
  end
endmodule : sic_scanner_inputs_test
